// *** logic/irqs_pkg.sv ***
/*
 interrupt request sequencer package: timing counts, vector layout,
 register map, reset values and the sequencer state encoding.
 assumes one core clock; a state time is a fixed number of core clocks.
*/
//
// Contract
// - every interrupt runs sample, poll, context switch request, then vector cycle.
// - exactly one prioritized request at a time becomes switch plus vector cycle.
// - block entry while same or higher level is in progress until its return.
// - block entry when polling is not in the instruction's final state.
// - block vectoring while the current instruction is a return from handler.
// - block vectoring while the instruction writes interrupt enable or priority.
// - blocked requests are not held; a cleared level flag is dropped.
// - when blocking ends, serve only the latest poll's choice.
// - vector cycle breaks stream, pushes program counter bytes, loads handler address.
// - vector width bit sets pushed byte count, pointer length, status word push.
// - return pops counter bytes, plus status word when width bit is 1.
// - hardware vectors spaced eight bytes apart; trap vector is the exception.
// - requests sampled on a recurring four state window.
// - external pins take one state more than internal sources.
// - pin sampled in first half of a state, polled in next state's second half.
// - external sample-to-request spans three to six states, internal one less.
// - pin rising one state after poll is not polled for three more states.
// - after recognition request the switch; vector follows instruction's final state.
// - request just before sample: one state samples, one requests the switch.
// - width bit 0 pushes bits 7:0 then 15:8; return lands in region ff.
// - width bit 1 pushes status, 23:16, 7:0, 15:8; return pops all four.
// - return re-arms acceptance at the level that just finished.
// - vector cycle takes 11 states; switch request takes one more.
//

package irqs_pkg;

   localparam int          STATE_CLKS    = 2;    // core clocks per state time
   localparam int          WIN_STATES    = 4;    // states per sample window
   localparam logic [1:0]  WIN_SAMPLE    = 2'h0; // pin sample state
   localparam logic [1:0]  WIN_POLL      = 2'h1; // poll/request state
   localparam int          VEC_STATES    = 11;   // vector cycle length
   localparam logic [3:0]  PUSH_NARROW   = 4'h2;
   localparam logic [3:0]  PUSH_WIDE     = 4'h4;
   localparam int          VEC_SHIFT     = 3;    // eight byte spacing
   localparam logic [23:0] VEC_BASE      = 24'hff0000;
   localparam logic [23:0] TRAP_VEC      = 24'hff0078;
   localparam logic [7:0]  NARROW_REGION = 8'hff;

   localparam logic [3:0]  ADDR_ENABLE   = 4'h0;
   localparam logic [3:0]  ADDR_PRIO     = 4'h1;
   localparam logic [3:0]  ADDR_CONFIG   = 4'h2;
   localparam logic [3:0]  ADDR_STATUS   = 4'h3;
   localparam logic [3:0]  ADDR_SELECT   = 4'h4;
   localparam int          EN_GLOBAL_BIT = 15;
   localparam int          CFG_VWS_BIT   = 0;
   localparam logic [15:0] ENABLE_RST    = 16'h0000;
   localparam logic [15:0] PRIO_RST      = 16'h0000;
   localparam logic        VWS_RST       = 1'b0;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_REQ     = 3'b001,
      ST_VECTOR  = 3'b010,
      ST_UNSTACK = 3'b011,
      ST_RESUME  = 3'b100
   } irqs_state_t;

endpackage : irqs_pkg

// *** logic/irqs_sequencer.sv ***
/*
 interrupt request sequencer: samples pins and internal requests on a
 four state window, polls by level, asks the execution unit for a context
 switch, runs the vector cycle over a byte stack port and unstacks on return.
 assumes all inputs synchronous to clk_sys and the execution unit reporting
 instruction boundaries every state.
*/
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module irqs_sequencer #(
   parameter int NUM_SRC = 8,
   parameter int NUM_EXT = 2
) (
   input  wire logic               clk_sys,         // core clock
   input  wire logic               reset_n,         // async reset
   input  wire logic [NUM_EXT-1:0] ext_pin,         // external request pins
   input  wire logic [NUM_SRC-NUM_EXT-1:0] int_req, // internal request flags
   input  wire logic               trap_req,        // software trap
   input  wire logic               instr_final,     // final state of instr
   input  wire logic               instr_is_return, // return from handler
   input  wire logic               instr_cfg_write, // writes enable/priority
   input  wire logic               ret_exec,        // return executes now
   input  wire logic [23:0]        pc_current,      // next instr address
   input  wire logic [7:0]         esw_current,     // extended status word
   input  wire logic [7:0]         stk_rdata,       // popped byte
   input  wire logic [3:0]         reg_addr,        // register address
   input  wire logic [15:0]        reg_wdata,       // register write data
   input  wire logic               reg_wr,          // write strobe
   input  wire logic               reg_rd,          // read strobe
   output logic [15:0]             reg_rdata,       // read data
   output logic                    state_tick,      // last clock of a state
   output logic                    ctx_switch_req,  // context switch request
   output logic                    stream_break,    // break instr stream
   output logic                    stk_push,        // push strobe
   output logic [7:0]              stk_wdata,       // pushed byte
   output logic                    stk_pop,         // pop strobe
   output logic                    pc_load,         // load program counter
   output logic [23:0]             pc_load_addr,    // new program counter
   output logic                    esw_load,        // restore status word
   output logic [7:0]              esw_load_data,   // restored status word
   output logic                    resume_done      // return completed
);

   localparam int DIV_W = $clog2(irqs_pkg::STATE_CLKS);
   localparam int IDX_W = $clog2(NUM_SRC);
   localparam int NLEV  = 4;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(irqs_pkg::STATE_CLKS - 1);
   localparam logic [3:0] VEC_LAST = 4'(irqs_pkg::VEC_STATES - 1);

   // priority register holds two bits per source, so at most eight sources
   if (NUM_SRC < 2 || NUM_SRC > 8 || NUM_EXT < 1 || NUM_EXT >= NUM_SRC) begin : g_bad_src
      $error("irqs_sequencer: unsupported source counts");
   end
   if (irqs_pkg::STATE_CLKS < 2) begin : g_bad_div
      $error("irqs_sequencer: a state needs two halves");
   end

   ////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [DIV_W-1:0]      div;
      logic [1:0]            win;
      logic [NUM_EXT-1:0]    ext_flag;
      logic [15:0]           en;
      logic [15:0]           prio;
      logic                  vws;
      logic [NLEV-1:0]       ip;
      logic                  trap_ip;
      irqs_pkg::irqs_state_t st;
      logic [IDX_W-1:0]      sel;
      logic [1:0]            sel_lvl;
      logic                  sel_trap;
      logic                  sel_valid;
      logic [3:0]            cnt;
      logic [23:0]           pc_save;
      logic [7:0]            esw_save;
      logic                  pop_pend;
      logic [31:0]           pop_buf;
      logic [15:0]           rdata;
      logic                  ctx_req;
      logic                  brk;
      logic                  push;
      logic [7:0]            wdata;
      logic                  pop;
      logic                  pcl;
      logic [23:0]           pc_addr;
      logic                  eswl;
      logic [7:0]            esw_data;
      logic                  done;
   } irqs_regs_t;

   irqs_regs_t r;
   irqs_regs_t n;

   logic                 tick;
   logic                 first_half;
   logic                 poll;
   logic                 instr_block;
   logic [NUM_SRC-1:0]   flags;
   logic                 best_ok;
   logic [1:0]           best_lvl;
   logic [IDX_W-1:0]     best_idx;
   logic [1:0]           lvl;
   logic [3:0]           n_bytes;
   logic [NLEV-1:0]      ip_clear;

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      n = r;
      n.brk = 1'b0;
      n.push = 1'b0;
      n.pop = 1'b0;
      n.pcl = 1'b0;
      n.eswl = 1'b0;
      n.done = 1'b0;
      n.rdata = 16'h0000;

      // state-time divider and window phase
      first_half = (r.div == '0);
      tick = (r.div == DIV_LAST);
      n.div = tick ? '0 : r.div + 1'b1;
      if (tick)
         n.win = r.win + 2'h1;
      poll = tick && (r.win == irqs_pkg::WIN_POLL);

      // pins latch early in the sample state; nothing is held past a sample
      if (first_half && r.win == irqs_pkg::WIN_SAMPLE)
         n.ext_flag = ext_pin;
      flags = {int_req, r.ext_flag};

      // level poll: higher level wins, ties go to the lowest source index
      best_ok = 1'b0;
      best_lvl = 2'h0;
      best_idx = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         lvl = r.prio[2*i +: 2];
         if (flags[i] && r.en[i] && r.en[irqs_pkg::EN_GLOBAL_BIT]
             && !(|(r.ip >> lvl))
             && (!best_ok || lvl > best_lvl)) begin
            best_ok = 1'b1;
            best_lvl = lvl;
            best_idx = IDX_W'(i);
         end
      end

      instr_block = !instr_final
                    || instr_is_return
                    || instr_cfg_write;

      n_bytes = r.vws ? irqs_pkg::PUSH_WIDE : irqs_pkg::PUSH_NARROW;

      // a non-trap return clears the highest level in progress
      ip_clear = '0;
      for (int j = 0; j < NLEV; j++) begin
         if (r.ip[j])
            ip_clear = NLEV'(1) << j;
      end

      unique case (r.st)
         irqs_pkg::ST_IDLE: begin
            if (poll) begin
               // the latest poll's pick replaces older ones
               n.sel_valid = best_ok || trap_req;
               n.sel = best_idx;
               n.sel_lvl = best_lvl;
               n.sel_trap = trap_req;
            end
            if (poll && !instr_block && (trap_req || best_ok)) begin
               n.st = irqs_pkg::ST_REQ;
               n.ctx_req = 1'b1;
            end else if (ret_exec) begin
               n.st = irqs_pkg::ST_UNSTACK;
               n.cnt = 4'h0;
            end
         end

         irqs_pkg::ST_REQ: begin
            // one request state, then the vector cycle starts
            if (tick) begin
               n.ctx_req = 1'b0;
               n.st = irqs_pkg::ST_VECTOR;
               n.cnt = 4'h0;
               n.brk = 1'b1;
               n.pc_save = pc_current;
               n.esw_save = esw_current;
               if (r.sel_trap)
                  n.trap_ip = 1'b1;
               else
                  n.ip = r.ip | (NLEV'(1) << r.sel_lvl);
            end
         end

         irqs_pkg::ST_VECTOR: begin
            if (tick) begin
               if (r.cnt < n_bytes) begin
                  n.push = 1'b1;
                  unique case ({r.vws, r.cnt[1:0]})
                     3'b000:  n.wdata = r.pc_save[7:0];
                     3'b001:  n.wdata = r.pc_save[15:8];
                     3'b100:  n.wdata = r.esw_save;
                     3'b101:  n.wdata = r.pc_save[23:16];
                     3'b110:  n.wdata = r.pc_save[7:0];
                     default: n.wdata = r.pc_save[15:8];
                  endcase
               end
               if (r.cnt == VEC_LAST) begin
                  n.pcl = 1'b1;
                  n.st = irqs_pkg::ST_IDLE;
                  n.sel_valid = 1'b0;
                  if (r.sel_trap)
                     n.pc_addr = irqs_pkg::TRAP_VEC;
                  else
                     n.pc_addr = irqs_pkg::VEC_BASE
                        + (24'(r.sel) << irqs_pkg::VEC_SHIFT);
               end else begin
                  n.cnt = r.cnt + 4'h1;
               end
            end
         end

         irqs_pkg::ST_UNSTACK: begin
            // stack answers one clock after each pop strobe, so capture
            // in the clock that follows the strobe, not alongside it
            n.pop_pend = r.pop;
            if (r.pop_pend)
               n.pop_buf = {r.pop_buf[23:0], stk_rdata};
            if (tick) begin
               if (r.cnt < n_bytes) begin
                  n.pop = 1'b1;
                  n.cnt = r.cnt + 4'h1;
               end else begin
                  n.st = irqs_pkg::ST_RESUME;
               end
            end
         end

         irqs_pkg::ST_RESUME: begin
            n.done = 1'b1;
            n.pcl = 1'b1;
            n.st = irqs_pkg::ST_IDLE;
            if (r.vws) begin
               n.pc_addr = {r.pop_buf[15:8], r.pop_buf[31:16]};
               n.eswl = 1'b1;
               n.esw_data = r.pop_buf[7:0];
            end else begin
               n.pc_addr = {irqs_pkg::NARROW_REGION,
                            r.pop_buf[15:0]};
            end
            if (r.trap_ip)
               n.trap_ip = 1'b0;
            else
               n.ip = r.ip & ~ip_clear;
         end

         default: begin
            n.st = irqs_pkg::ST_IDLE;
            n.ctx_req = 1'b0;
         end
      endcase

      //////////////////////////////////////////////////////////////////
      // register port

      if (reg_wr) begin
         unique case (reg_addr)
            irqs_pkg::ADDR_ENABLE: n.en = reg_wdata;
            irqs_pkg::ADDR_PRIO:   n.prio = reg_wdata;
            irqs_pkg::ADDR_CONFIG: n.vws = reg_wdata[irqs_pkg::CFG_VWS_BIT];
            default:               n.en = n.en;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            irqs_pkg::ADDR_ENABLE: n.rdata = r.en;
            irqs_pkg::ADDR_PRIO:   n.rdata = r.prio;
            irqs_pkg::ADDR_CONFIG: n.rdata = {15'h0000, r.vws};
            irqs_pkg::ADDR_STATUS: n.rdata = {8'(flags), r.trap_ip,
                                              r.st, r.ip};
            irqs_pkg::ADDR_SELECT: n.rdata = {r.sel_valid, r.sel_trap,
                                              9'h000, r.sel_lvl,
                                              3'(r.sel)};
            default:               n.rdata = 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
         r.st <= irqs_pkg::ST_IDLE;
         r.en <= irqs_pkg::ENABLE_RST;
         r.prio <= irqs_pkg::PRIO_RST;
         r.vws <= irqs_pkg::VWS_RST;
      end else begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign reg_rdata = r.rdata;
   assign state_tick = (r.div == DIV_LAST);
   assign ctx_switch_req = r.ctx_req;
   assign stream_break = r.brk;
   assign stk_push = r.push;
   assign stk_wdata = r.wdata;
   assign stk_pop = r.pop;
   assign pc_load = r.pcl;
   assign pc_load_addr = r.pc_addr;
   assign esw_load = r.eswl;
   assign esw_load_data = r.esw_data;
   assign resume_done = r.done;

endmodule : irqs_sequencer

`default_nettype wire

// *** tb/irqs_sequencer_properties.sv ***
/*
 checker for the interrupt request sequencer: switch request, vector cycle,
 pushes, return and state timing. assumes two core clocks per state time.
*/
`timescale 1ns/1ns
`default_nettype none

module irqs_sequencer_properties (
   input wire logic        clk_sys,         // core clock
   input wire logic        reset_n,         // async reset
   input wire logic        instr_final,     // final state of instr
   input wire logic        instr_is_return, // return from handler
   input wire logic        instr_cfg_write, // writes enable/priority
   input wire logic        state_tick,      // last clock of a state
   input wire logic        ctx_switch_req,  // context switch request
   input wire logic        stream_break,    // break instr stream
   input wire logic        stk_push,        // push strobe
   input wire logic        pc_load,         // load program counter
   input wire logic [23:0] pc_load_addr,    // new program counter
   input wire logic        esw_load,        // restore status word
   input wire logic        resume_done      // return completed
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////////////////
   property p_req_len;
      $rose(ctx_switch_req) |-> ctx_switch_req [*2] ##1 !ctx_switch_req;
   endproperty
   a_req_len: assert property (p_req_len) else $error("request not one state");
   property p_unblocked;
      $rose(ctx_switch_req) |-> $past(instr_final) && !$past(instr_is_return)
         && !$past(instr_cfg_write);
   endproperty
   a_unblocked: assert property (p_unblocked) else $error("request while blocked");
   property p_poll_tick;
      $rose(ctx_switch_req) |-> $past(state_tick);
   endproperty
   a_poll_tick: assert property (p_poll_tick) else $error("poll off state end");
   property p_break;
      $fell(ctx_switch_req) |-> stream_break;
   endproperty
   a_break: assert property (p_break) else $error("no break after request");
   property p_vec_len;
      stream_break |-> ##22 (pc_load && pc_load_addr[2:0] == 3'h0);
   endproperty
   a_vec_len: assert property (p_vec_len) else $error("vector cycle length");
   property p_push;
      stream_break |-> ##2 stk_push;
   endproperty
   a_push: assert property (p_push) else $error("first push late");
   property p_resume;
      resume_done |-> pc_load;
   endproperty
   a_resume: assert property (p_resume) else $error("return without load");
   property p_region;
      resume_done && !esw_load |-> pc_load_addr[23:16] == 8'hff;
   endproperty
   a_region: assert property (p_region) else $error("narrow return region");
   property p_tick;
      state_tick |=> !state_tick ##1 state_tick;
   endproperty
   a_tick: assert property (p_tick) else $error("state time length");
   c_req: cover property ($rose(ctx_switch_req));
   c_ret: cover property (resume_done);
   c_wide: cover property (resume_done && esw_load);
endmodule : irqs_sequencer_properties

`default_nettype wire

// *** tb/irqs_partner.sv ***
/*
 stack memory of the execution unit: lifo of bytes for pushes and pops.
 assumes one push or pop strobe per clock; depth of sixteen bytes.
*/
`timescale 1ns/1ns
`default_nettype none

module irqs_partner (
   input  wire logic       clk_sys,   // core clock
   input  wire logic       reset_n,   // async reset
   input  wire logic       stk_push,  // push strobe
   input  wire logic [7:0] stk_wdata, // pushed byte
   input  wire logic       stk_pop,   // pop strobe
   output logic      [7:0] stk_rdata, // popped byte
   output logic      [3:0] sp         // stack depth
);
   logic [7:0] mem [0:15];
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sp        <= 4'h0;
         stk_rdata <= 8'h00;
      end else if (stk_push) begin
         mem[sp] <= stk_wdata;
         sp      <= sp + 4'h1;
      end else if (stk_pop) begin
         stk_rdata <= mem[sp - 4'h1];
         sp        <= sp - 4'h1;
      end else begin
         // bus not holding its last byte, so a late capture shows up
         stk_rdata <= ~stk_rdata;
      end
   end
endmodule : irqs_partner

`default_nettype wire

// *** tb/irqs_sequencer_tb.sv ***
/*
 testbench of the interrupt request sequencer: registers, tie order,
 in-progress blocking, instruction blocking, trap, wide mode external pin.
 assumes the stack partner model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none

module irqs_sequencer_tb;
   logic        clk_sys, reset_n, trap_req, instr_final, instr_is_return;
   logic        instr_cfg_write, ret_exec, reg_wr, reg_rd, state_tick;
   logic        ctx_switch_req, stream_break, stk_push, stk_pop, pc_load;
   logic        esw_load, resume_done;
   logic [1:0]  ext_pin;
   logic [5:0]  int_req;
   logic [23:0] pc_current, pc_load_addr;
   logic [7:0]  esw_current, stk_rdata, stk_wdata, esw_load_data;
   logic [3:0]  reg_addr, sp;
   logic [15:0] reg_wdata, reg_rdata;
   int          num_errors, cmp_count;

   irqs_sequencer i_irqs_sequencer (.clk_sys(clk_sys), .reset_n(reset_n), .ext_pin(ext_pin),
      .int_req(int_req), .trap_req(trap_req), .instr_final(instr_final),
      .instr_is_return(instr_is_return), .instr_cfg_write(instr_cfg_write),
      .ret_exec(ret_exec), .pc_current(pc_current), .esw_current(esw_current),
      .stk_rdata(stk_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .state_tick(state_tick),
      .ctx_switch_req(ctx_switch_req), .stream_break(stream_break), .stk_push(stk_push),
      .stk_wdata(stk_wdata), .stk_pop(stk_pop), .pc_load(pc_load),
      .pc_load_addr(pc_load_addr), .esw_load(esw_load), .esw_load_data(esw_load_data),
      .resume_done(resume_done));
   irqs_partner i_irqs_partner (.clk_sys(clk_sys), .reset_n(reset_n), .stk_push(stk_push),
      .stk_wdata(stk_wdata), .stk_pop(stk_pop), .stk_rdata(stk_rdata), .sp(sp));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict

   task automatic check_val(input string name, input logic [23:0] exp, input logic [23:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask : check_val

   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_check(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      check_val("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
   endtask : reg_check

   // bounded wait: 0 switch request, 1 vector load, 2 return done
   task automatic wait_for(input int which, input int lim);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < lim && !hit; i++) begin
         @(posedge clk_sys);
         #1;
         hit = (which == 0) ? (ctx_switch_req === 1'b1) :
               (which == 1) ? (pc_load === 1'b1) : (resume_done === 1'b1);
      end
      if (!hit) begin
         $display("[ERR] wait %0d expected 1 seen 0", which);
         num_errors++;
         print_verdict();
      end
   endtask : wait_for

   task automatic expect_quiet(input int n);
      logic seen;
      seen = 1'b0;
      repeat (n) begin
         @(posedge clk_sys);
         #1;
         if (ctx_switch_req !== 1'b0) seen = 1'b1;
      end
      check_val("ctx_switch_req", 24'h0, {23'h0, seen});
   endtask : expect_quiet

   task automatic serve_vec(input logic [23:0] vec, input logic wide, input int lim);
      wait_for(0, lim);
      wait_for(1, 30);
      check_val("vector", vec, pc_load_addr);
      check_val("depth", wide ? 24'h4 : 24'h2, {20'h0, sp});
      if (wide) begin
         check_val("push0", {16'h0, esw_current}, {16'h0, i_irqs_partner.mem[0]});
         check_val("push1", {16'h0, pc_current[23:16]}, {16'h0, i_irqs_partner.mem[1]});
      end
      check_val("pushlo", pc_current[7:0], i_irqs_partner.mem[wide ? 2 : 0]);
      check_val("pushhi", pc_current[15:8], i_irqs_partner.mem[wide ? 3 : 1]);
   endtask : serve_vec

   task automatic serve_ret(input logic wide);
      repeat (2) @(posedge clk_sys);
      ret_exec <= 1'b1;
      @(posedge clk_sys);
      ret_exec <= 1'b0;
      wait_for(2, 40);
      check_val("ret_addr", wide ? pc_current : {8'hff, pc_current[15:0]}, pc_load_addr);
      if (wide) check_val("esw", {16'h0, esw_current}, {16'h0, esw_load_data});
      check_val("esw_load", {23'h0, wide}, {23'h0, esw_load});
   endtask : serve_ret

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   initial begin
      {reset_n, trap_req, instr_is_return, instr_cfg_write, ret_exec, reg_wr, reg_rd} = '0;
      {ext_pin, int_req, reg_addr, reg_wdata} = '0;
      instr_final = 1'b1;
      pc_current  = 24'h3c8a71;
      esw_current = 8'h5a;
      num_errors  = 0;
      cmp_count   = 0;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      reg_check(irqs_pkg::ADDR_ENABLE, irqs_pkg::ENABLE_RST);
      reg_check(irqs_pkg::ADDR_PRIO, irqs_pkg::PRIO_RST);
      reg_check(irqs_pkg::ADDR_CONFIG, {15'h0, irqs_pkg::VWS_RST});
      reg_write(irqs_pkg::ADDR_ENABLE, 16'h80ff);
      reg_write(irqs_pkg::ADDR_PRIO, 16'h5555);
      reg_check(irqs_pkg::ADDR_ENABLE, 16'h80ff);
      reg_check(irqs_pkg::ADDR_PRIO, 16'h5555);
      reg_check(4'hf, 16'h0000);
      $display("test registers done");
      // equal levels: lower index first, the other waits for the return
      @(posedge clk_sys);
      int_req <= 6'h0a;
      serve_vec(irqs_pkg::VEC_BASE + (24'h3 << irqs_pkg::VEC_SHIFT), 1'b0, 12);
      int_req <= 6'h08;
      expect_quiet(16);
      serve_ret(1'b0);
      serve_vec(irqs_pkg::VEC_BASE + (24'h5 << irqs_pkg::VEC_SHIFT), 1'b0, 12);
      int_req <= 6'h00;
      serve_ret(1'b0);
      $display("test priority done");
      for (int k = 0; k < 3; k++) begin
         instr_final     <= (k != 0);
         instr_cfg_write <= (k == 1);
         instr_is_return <= (k == 2);
         int_req         <= 6'h01;
         expect_quiet(24);
         int_req         <= 6'h00;
         {instr_cfg_write, instr_is_return} <= 2'b00;
         instr_final     <= 1'b1;
         expect_quiet(16);
      end
      $display("test blocking done");
      trap_req <= 1'b1;
      serve_vec(irqs_pkg::TRAP_VEC, 1'b0, 12);
      trap_req <= 1'b0;
      serve_ret(1'b0);
      $display("test trap done");
      reg_write(irqs_pkg::ADDR_CONFIG, 16'h0001);
      reg_check(irqs_pkg::ADDR_CONFIG, 16'h0001);
      @(posedge clk_sys);
      ext_pin <= 2'b01;
      serve_vec(irqs_pkg::VEC_BASE, 1'b1, 14);
      ext_pin <= 2'b00;
      serve_ret(1'b1);
      $display("test wide external done");
      print_verdict();
   end
endmodule : irqs_sequencer_tb

bind irqs_sequencer irqs_sequencer_properties i_irqs_sequencer_properties (
   .clk_sys(clk_sys), .reset_n(reset_n), .instr_final(instr_final),
   .instr_is_return(instr_is_return), .instr_cfg_write(instr_cfg_write),
   .state_tick(state_tick), .ctx_switch_req(ctx_switch_req), .stream_break(stream_break),
   .stk_push(stk_push), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
   .esw_load(esw_load), .resume_done(resume_done));

`default_nettype wire
